// ==== rtl/slq_status_lamp.sv ====
// status lamp sequencer: maps device status to red and blue lamp patterns
`timescale 1ns/1ps
module slq_status_lamp
	import slq_pkg::*;
#(
	parameter int RAPID_HALF = RAPID_CYC,
	parameter int SLOW_HALF = SLOW_CYC,
	parameter int VSLOW_HALF = VSLOW_CYC
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire slq_cond_t STATUS,
	output logic LAMP_RED,
	output logic LAMP_BLUE,
	output slq_mode_t MODE
);
	typedef struct packed {
		slq_mode_t mode;
		logic red;
		logic blue;
	} slq_state_t;

	slq_state_t st;
	slq_state_t next_st;
	logic rapid_ph;
	logic slow_ph;
	logic vslow_ph;
	logic hi_fw;
	logic hi_fault;
	logic hi_loc;
	logic hi_unplug;
	// connected-level qualifier hi_conn, then exclusive qualifiers for the lower levels, one per displayed mode, read by the checks
	logic hi_conn;
	logic hi_ext;
	logic hi_rapid;
	logic hi_slow;
	logic hi_idle;
	logic hi_off;

	// ***********************************************
	// elaboration check
	// ***********************************************
	if (RAPID_HALF >= SLOW_HALF || SLOW_HALF >= VSLOW_HALF) begin : g_bad
		$error("flash rates must run rapid, slow, very slow");
	end

	// ***********************************************
	// flash phase generators
	// ***********************************************
	// the three timers free-run from reset, so a pattern entered mid-period starts at
	// the current phase and its first dark interval may be short; they share CE so
	// that update alternation and the very slow red stay in step with each other
	slq_flash_timer #(.HALF_CYCLES(RAPID_HALF)) u_rapid (
		.clock(CLOCK),
		.rst(RST),
		.ce(CE),
		.phase(rapid_ph)
	);
	slq_flash_timer #(.HALF_CYCLES(SLOW_HALF)) u_slow (
		.clock(CLOCK),
		.rst(RST),
		.ce(CE),
		.phase(slow_ph)
	);
	slq_flash_timer #(.HALF_CYCLES(VSLOW_HALF)) u_vslow (
		.clock(CLOCK),
		.rst(RST),
		.ce(CE),
		.phase(vslow_ph)
	);

	// priority qualifiers, each true only when no higher condition holds
	assign hi_fw = STATUS.fw_updating;
	assign hi_fault = !hi_fw && STATUS.fault;
	assign hi_loc = !hi_fw && !STATUS.fault && STATUS.locate_request;
	assign hi_unplug = !hi_fw && !STATUS.fault && !STATUS.locate_request
		&& !STATUS.cable_connected;

	// connected with nothing above it; acquisition, idle and off split this level
	assign hi_conn = !hi_fw && !STATUS.fault && !STATUS.locate_request
		&& STATUS.cable_connected;
	assign hi_ext = hi_conn && STATUS.acq_running && STATUS.acq_ext_trig;
	assign hi_rapid = hi_conn && STATUS.acq_running && !STATUS.acq_ext_trig
		&& STATUS.link_superspeed;
	assign hi_slow = hi_conn && STATUS.acq_running && !STATUS.acq_ext_trig
		&& !STATUS.link_superspeed;
	assign hi_idle = hi_conn && !STATUS.acq_running && STATUS.device_ready;
	assign hi_off = hi_conn && !STATUS.acq_running && !STATUS.device_ready;

	// ***********************************************
	// mode selection and lamp drive
	// ***********************************************
	always_comb begin
		next_st = st;
		if (STATUS.fw_updating) begin
			next_st.mode = MODE_FW_ALT;
		end else if (STATUS.fault) begin
			next_st.mode = MODE_FAULT;
		end else if (STATUS.locate_request) begin
			next_st.mode = MODE_LOCATE;
		end else if (!STATUS.cable_connected) begin
			next_st.mode = MODE_UNPLUG;
		end else if (STATUS.acq_running && STATUS.acq_ext_trig) begin
			next_st.mode = MODE_VSLOW;
		end else if (STATUS.acq_running && STATUS.link_superspeed) begin
			next_st.mode = MODE_RAPID;
		end else if (STATUS.acq_running) begin
			next_st.mode = MODE_SLOW;
		end else if (STATUS.device_ready) begin
			next_st.mode = MODE_IDLE;
		end else begin
			next_st.mode = MODE_OFF; // connected but not ready yet
		end
		// lamps default dark; the case lights only what the mode calls for
		next_st.red = LAMP_RST;
		next_st.blue = LAMP_RST;
		unique case (next_st.mode)
			MODE_FW_ALT: begin
				next_st.red = slow_ph;
				next_st.blue = ~slow_ph;
			end
			MODE_FAULT: next_st.red = 1'h1;
			MODE_LOCATE: next_st.red = 1'h1;
			MODE_UNPLUG: next_st.red = vslow_ph;
			MODE_IDLE: next_st.blue = 1'h1;
			MODE_RAPID: next_st.blue = rapid_ph;
			MODE_SLOW: next_st.blue = slow_ph;
			MODE_VSLOW: next_st.blue = vslow_ph;
			MODE_OFF: ;
		endcase
	end

	// state register, frozen while CE is low
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st <= '{mode: MODE_OFF, red: LAMP_RST, blue: LAMP_RST};
		end else if (CE) begin
			st <= next_st;
		end
	end

	assign LAMP_RED = st.red;
	assign LAMP_BLUE = st.blue;
	assign MODE = st.mode;

	// ***********************************************
	// checks
	// ***********************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence alt_s;
		(LAMP_RED != LAMP_BLUE) && LAMP_RED == $past(slow_ph);
	endsequence

	fw_alternate_a: assert property ((CE && hi_fw) |=> alt_s)
		else $error("lamps not alternating during update");
	// steady red with blue dark, shared by fault and locate
	sequence red_solid_s;
		LAMP_RED && !LAMP_BLUE;
	endsequence

	// two enabled update edges in a row, the slow phase flipping on the first
	sequence fw_flip_s;
		(CE && hi_fw) ##1 (CE && hi_fw && $changed(slow_ph));
	endsequence

	// solid red patterns
	fault_solid_a: assert property ((CE && hi_fault) |=> red_solid_s)
		else $error("fault not shown as solid red");
	locate_red_a: assert property ((CE && hi_loc) |=> red_solid_s)
		else $error("locate not shown as red");

	// lamp patterns one enabled edge later, the flashing ones following their timer phase
	unplug_flash_a: assert property ((CE && hi_unplug)
		|=> LAMP_RED == $past(vslow_ph) && !LAMP_BLUE)
		else $error("unplugged not shown as very slow red");
	idle_blue_a: assert property ((CE && hi_idle)
		|=> LAMP_BLUE && !LAMP_RED && MODE == MODE_IDLE)
		else $error("idle not shown as solid blue");
	// acquisition patterns need only a connected cable; ready matters only for idle and off
	rapid_blue_a: assert property ((CE && hi_rapid)
		|=> LAMP_BLUE == $past(rapid_ph) && !LAMP_RED && MODE == MODE_RAPID)
		else $error("usb3 internal acquisition not rapid blue");
	slow_blue_a: assert property ((CE && hi_slow)
		|=> LAMP_BLUE == $past(slow_ph) && !LAMP_RED && MODE == MODE_SLOW)
		else $error("usb2 internal acquisition not slow blue");
	ext_blue_a: assert property ((CE && hi_ext)
		|=> LAMP_BLUE == $past(vslow_ph) && !LAMP_RED && MODE == MODE_VSLOW)
		else $error("external acquisition not very slow blue");
	fw_swap_a: assert property (fw_flip_s |=> $changed(LAMP_RED) && $changed(LAMP_BLUE))
		else $error("lamps did not swap at slow phase flip");

	// the displayed mode follows the priority order one enabled edge later
	mode_fw_a: assert property ((CE && hi_fw) |=> MODE == MODE_FW_ALT)
		else $error("update not shown as top priority");
	mode_fault_a: assert property ((CE && hi_fault) |=> MODE == MODE_FAULT)
		else $error("fault mode not selected");
	mode_locate_a: assert property ((CE && hi_loc) |=> MODE == MODE_LOCATE)
		else $error("locate mode not selected");
	mode_unplug_a: assert property ((CE && hi_unplug) |=> MODE == MODE_UNPLUG)
		else $error("unplugged mode not selected");
	off_dark_a: assert property ((CE && hi_off)
		|=> !LAMP_RED && !LAMP_BLUE && MODE == MODE_OFF)
		else $error("connected but not ready did not leave both lamps dark");
	one_colour_a: assert property (!(LAMP_RED && LAMP_BLUE))
		else $error("both lamps lit at once");
	// outputs dark and mode off while reset is held; this one is not disabled by reset
	reset_dark_a: assert property (disable iff (1'h0) RST
		|-> !LAMP_RED && !LAMP_BLUE && MODE == MODE_OFF)
		else $error("outputs not cleared during reset");
	freeze_a: assert property (!CE |=> $stable(st))
		else $error("state moved while clock enable low");

endmodule

// ==== rtl/slq_pkg.sv ====
// shared types and constants of the status lamp sequencer
package slq_pkg;

	// ***********************************************
	// timing
	// ***********************************************
	localparam int CLOCK_HZ = 40_000_000;
	localparam int CYC_PER_MS = CLOCK_HZ / 1000;
	localparam int RAPID_OFF_MS = 200;   // 0.2 sec unlit
	localparam int SLOW_OFF_MS = 1000;   // 1 sec unlit
	localparam int VSLOW_OFF_MS = 2000;  // 2 sec unlit
	localparam int RAPID_CYC = RAPID_OFF_MS * CYC_PER_MS;
	localparam int SLOW_CYC = SLOW_OFF_MS * CYC_PER_MS;
	localparam int VSLOW_CYC = VSLOW_OFF_MS * CYC_PER_MS;
	localparam int MIN_HALF_CYC = 2;

	// ***********************************************
	// reset values
	// ***********************************************
	localparam logic LAMP_RST = 1'h0;
	localparam logic PHASE_RST = 1'h0;

	// ***********************************************
	// status inputs and display modes
	// ***********************************************
	typedef struct packed {
		logic fw_updating;      // firmware update in progress
		logic fault;            // update or config read failed, other exception
		logic locate_request;   // host locate function running
		logic cable_connected;  // host data cable detected
		logic device_ready;     // device ready for acquisition
		logic acq_running;      // images being acquired
		logic acq_ext_trig;     // acquisition under external triggering
		logic link_superspeed;  // link at the USB 3.0 rated speed
	} slq_cond_t;

	typedef enum logic [3:0] {
		MODE_OFF,
		MODE_FW_ALT,
		MODE_FAULT,
		MODE_LOCATE,
		MODE_UNPLUG,
		MODE_IDLE,
		MODE_RAPID,
		MODE_SLOW,
		MODE_VSLOW
	} slq_mode_t;

endpackage

// ==== rtl/slq_flash_timer.sv ====
// square wave phase generator with equal lit and unlit halves
`timescale 1ns/1ps
module slq_flash_timer
	import slq_pkg::*;
#(
	parameter int HALF_CYCLES = RAPID_CYC
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	output logic phase
);
	localparam int CW = $clog2(HALF_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic phase;
	} slq_tmr_t;

	slq_tmr_t st;
	slq_tmr_t next_st;

	// ***********************************************
	// elaboration check
	// ***********************************************
	if (HALF_CYCLES < MIN_HALF_CYC) begin : g_bad
		$error("half period too short");
	end

	// count cycles and flip the phase every half period
	always_comb begin
		next_st = st;
		if (st.cnt == LAST) begin
			next_st.cnt = '0;
			next_st.phase = ~st.phase;
		end else begin
			next_st.cnt = st.cnt + 1'h1;
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st <= '{cnt: '0, phase: PHASE_RST};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign phase = st.phase;

	// ***********************************************
	// checks
	// ***********************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	phase_hold_a: assert property ((ce && st.cnt != LAST) |=> $stable(st.phase))
		else $error("phase changed before half period ended");
	phase_flip_a: assert property ((ce && st.cnt == LAST) |=> st.phase != $past(st.phase))
		else $error("phase did not flip at half period end");

endmodule

// ==== tb/slq_lamp_model.sv ====
// model of the red and blue lamp drivers, measuring each unlit interval
`timescale 1ns/1ps
module slq_lamp_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic red,
	input wire logic blue,
	output logic [15:0] red_off,
	output logic [15:0] blue_off
);
	logic [15:0] red_run;
	logic [15:0] blue_run;

	// ***********************************************
	// unlit run counters
	// ***********************************************
	// count dark enabled edges; a lamp turning on latches the finished run
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			red_run <= 16'h0;
			blue_run <= 16'h0;
			red_off <= 16'h0;
			blue_off <= 16'h0;
		end else if (ce) begin
			red_run <= red ? 16'h0 : red_run + 16'h1;
			blue_run <= blue ? 16'h0 : blue_run + 16'h1;
			if (red && red_run != 16'h0) begin
				red_off <= red_run;
			end
			if (blue && blue_run != 16'h0) begin
				blue_off <= blue_run;
			end
		end
	end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the status lamp sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: lamp or mode mismatch", $time); end end
module tb_top import slq_pkg::*;;
	typedef struct packed {
		slq_cond_t st;
		slq_mode_t md;
		logic r;
		logic b;
		logic [15:0] ro;
		logic [15:0] bo;
	} slq_row_t;
	logic CLOCK = 1'h0;
	logic RST = 1'h0;
	logic CE = 1'h1;
	slq_cond_t STATUS = 8'h00;
	logic LAMP_RED;
	logic LAMP_BLUE;
	slq_mode_t MODE;
	logic [15:0] red_off;
	logic [15:0] blue_off;
	int error_cnt = 0;
	int tests_run = 0;
	slq_row_t rows [13];

	// 40 MHz clock
	always #12.5 CLOCK = ~CLOCK;

	slq_status_lamp #(.RAPID_HALF(4), .SLOW_HALF(8), .VSLOW_HALF(16)) dut (
		.CLOCK(CLOCK), .RST(RST), .CE(CE), .STATUS(STATUS),
		.LAMP_RED(LAMP_RED), .LAMP_BLUE(LAMP_BLUE), .MODE(MODE));

	slq_lamp_model lamps (.clock(CLOCK), .rst(RST), .ce(CE), .red(LAMP_RED),
		.blue(LAMP_BLUE), .red_off(red_off), .blue_off(blue_off));

	// wait n edges, then step just past the edge
	task automatic step(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask

	// ***********************************************
	// verdict
	// ***********************************************
	task automatic end_of_test();
		$display("errors %0d, checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// status, mode, solid red, solid blue, red unlit, blue unlit
	initial begin
		rows = '{
			'{8'h40, MODE_FAULT, 1'h1, 1'h0, 16'h0, 16'h0},
			'{8'hC0, MODE_FW_ALT, 1'h0, 1'h0, 16'h8, 16'h8},
			'{8'h20, MODE_LOCATE, 1'h1, 1'h0, 16'h0, 16'h0},
			'{8'h60, MODE_FAULT, 1'h1, 1'h0, 16'h0, 16'h0},
			'{8'h06, MODE_UNPLUG, 1'h0, 1'h0, 16'h10, 16'h0},
			'{8'h24, MODE_LOCATE, 1'h1, 1'h0, 16'h0, 16'h0},
			'{8'h18, MODE_IDLE, 1'h0, 1'h1, 16'h0, 16'h0},
			'{8'h10, MODE_OFF, 1'h0, 1'h0, 16'h0, 16'h0},
			'{8'h15, MODE_RAPID, 1'h0, 1'h0, 16'h0, 16'h4},
			'{8'h14, MODE_SLOW, 1'h0, 1'h0, 16'h0, 16'h8},
			'{8'h16, MODE_VSLOW, 1'h0, 1'h0, 16'h0, 16'h10},
			'{8'h17, MODE_VSLOW, 1'h0, 1'h0, 16'h0, 16'h10},
			'{8'h1D, MODE_RAPID, 1'h0, 1'h0, 16'h0, 16'h4}
		};
		// raise reset as a real edge so every asynchronous reset branch runs
		#1;
		RST = 1'h1;
		step(16);
		RST = 1'h0;
		// each status held 60 edges, more than one whole very slow period of 32
		foreach (rows[i]) begin
			STATUS = rows[i].st;
			step(60);
			`CHK(MODE, rows[i].md)
			if (rows[i].ro != 16'h0) `CHK(red_off, rows[i].ro) else `CHK(LAMP_RED, rows[i].r)
			if (rows[i].bo != 16'h0) `CHK(blue_off, rows[i].bo) else `CHK(LAMP_BLUE, rows[i].b)
			if (rows[i].md == MODE_FW_ALT) `CHK(LAMP_RED ^ LAMP_BLUE, 1'h1)
		end
		// second reset mid-run; fault must show one edge after release
		RST = 1'h1;
		STATUS = 8'h40;
		step(2);
		RST = 1'h0;
		step(1);
		`CHK(MODE, MODE_FAULT)
		`CHK(LAMP_RED, 1'h1)
		// frozen while disabled, then idle taken on the next enabled edge
		CE = 1'h0;
		STATUS = 8'h18;
		step(4);
		`CHK(LAMP_RED, 1'h1)
		`CHK(MODE, MODE_FAULT)
		`CHK(LAMP_BLUE, 1'h0)
		CE = 1'h1;
		step(1);
		`CHK(MODE, MODE_IDLE)
		`CHK(LAMP_BLUE, 1'h1)
		end_of_test();
	end
endmodule
